// ---- rtl/performance_monitor_defs.svh ----
/*
 Register word indices (paddr[13:2]), reset values and widths of the error counter bank.
 Assumes inclusion by bare name from the package and modules.
*/
`ifndef PERFORMANCE_MONITOR_DEFS_SVH
`define PERFORMANCE_MONITOR_DEFS_SVH
`define ZV_HIGH_IDX      12'h910
`define ZV_LOW_IDX       12'h911
`define FCS2_IDX         12'h91c
`define FCS3_IDX         12'h92c
`define INT_STATUS_IDX   12'h940
`define INT_MASK_IDX     12'h941
`define ZV_WIDTH         16
`define FCS_WIDTH        8
`define CNT_RESET        16'h0000
`define BYTE_RESET       8'h00
`define INT_BITS         3
`define INT_ZV_BIT       0
`define INT_FCS2_BIT     1
`define INT_FCS3_BIT     2
`define WORD_ZERO        32'h00000000
`define ADDR_LSB         2
`endif

// ---- rtl/performance_monitor_pkg.sv ----
/*
 Types shared by the error counter bank.
 Assumes performance_monitor_defs.svh is on the include path.
*/
package performance_monitor_pkg;
`include "performance_monitor_defs.svh"
   typedef enum logic [1:0] {
      rd_idle,
      rd_high_seen
   } pair_state_t;
endpackage

// ---- rtl/sat_counter.sv ----
/*
 Saturating clear-on-read event counter.
 Assumes events and clears are synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sat_counter #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             clk_en,
   // Control
   input  wire logic             event_in,
   input  wire logic             clear,
   // Value
   output logic [WIDTH-1:0]      count
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } cnt_state_t;

   cnt_state_t state_r;
   cnt_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      if (clear) begin
         // Event during clearing read counts after the clear
         state_nxt.cnt = event_in ? WIDTH'(1) : '0;
      end else if (event_in && !(&state_r.cnt)) begin
         state_nxt.cnt = state_r.cnt + WIDTH'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= '0;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   assign count = state_r.cnt;
endmodule // sat_counter
`default_nettype wire

// ---- rtl/performance_monitor_error_counters.sv ----
/*
 Per-channel error counter bank with APB slave and interrupt.
 Assumes event inputs are one-cycle pulses on pclk; APB master on pclk.
*/
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "performance_monitor_defs.svh"
module performance_monitor_error_counters
   import performance_monitor_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Events
   input  wire logic        zero_violation_event,
   input  wire logic        ctrl2_fcs_error_event,
   input  wire logic        ctrl3_fcs_error_event,
   // Interrupt
   output logic             irq
);
   typedef struct packed {
      pair_state_t                pair;
      logic [7:0]                 low_latch;
      logic [`INT_BITS-1:0]       int_status;
      logic [`INT_BITS-1:0]       int_mask;
      logic [31:0]                rdata;
      logic                       ready;
      logic                       slverr;
      logic                       irq;
   } bank_state_t;

   bank_state_t state_r;
   bank_state_t state_nxt;

   logic [`ZV_WIDTH-1:0]  zv_count;
   logic [`FCS_WIDTH-1:0] fcs2_count;
   logic [`FCS_WIDTH-1:0] fcs3_count;
   logic                  zv_clear;
   logic                  fcs2_clear;
   logic                  fcs3_clear;
   logic                  setup;
   logic [11:0]           idx;
   logic                  aligned;
   logic                  rd_hit_high;
   logic                  rd_hit_low;
   logic                  rd_hit_fcs2;
   logic                  rd_hit_fcs3;
   logic [`INT_BITS-1:0]  events;

   // Setup phase: answer registered for the access phase
   assign setup   = psel && !penable;
   assign idx     = paddr[13:2];
   assign aligned = (paddr[1:0] == 2'b00) && (paddr[15:14] == 2'b00);

   assign rd_hit_high = setup && !pwrite && aligned && (idx == `ZV_HIGH_IDX);
   assign rd_hit_low  = setup && !pwrite && aligned && (idx == `ZV_LOW_IDX);
   assign rd_hit_fcs2 = setup && !pwrite && aligned && (idx == `FCS2_IDX);
   assign rd_hit_fcs3 = setup && !pwrite && aligned && (idx == `FCS3_IDX);

   // Full count cleared when high byte read; low byte latched for pairing
   assign zv_clear   = rd_hit_high;
   assign fcs2_clear = rd_hit_fcs2;
   assign fcs3_clear = rd_hit_fcs3;

   assign events = {ctrl3_fcs_error_event, ctrl2_fcs_error_event, zero_violation_event};

   sat_counter #(
      .WIDTH (`ZV_WIDTH)
   ) u_zv (
      .pclk     (pclk),
      .presetn  (presetn),
      .clk_en   (clk_en),
      .event_in (zero_violation_event),
      .clear    (zv_clear),
      .count    (zv_count)
   );

   sat_counter #(
      .WIDTH (`FCS_WIDTH)
   ) u_fcs2 (
      .pclk     (pclk),
      .presetn  (presetn),
      .clk_en   (clk_en),
      .event_in (ctrl2_fcs_error_event),
      .clear    (fcs2_clear),
      .count    (fcs2_count)
   );

   sat_counter #(
      .WIDTH (`FCS_WIDTH)
   ) u_fcs3 (
      .pclk     (pclk),
      .presetn  (presetn),
      .clk_en   (clk_en),
      .event_in (ctrl3_fcs_error_event),
      .clear    (fcs3_clear),
      .count    (fcs3_count)
   );

   always_comb begin
      state_nxt        = state_r;
      state_nxt.ready  = 1'b0;
      state_nxt.slverr = 1'b0;
      // Sticky events, set wins over clear
      state_nxt.int_status = state_r.int_status | events;
      if (setup) begin
         state_nxt.ready = 1'b1;
         state_nxt.rdata = `WORD_ZERO;
         if (!aligned) begin
            state_nxt.slverr = 1'b1;
         end else if (pwrite) begin
            case (idx)
               `INT_STATUS_IDX: begin
                  state_nxt.int_status = (state_r.int_status & ~pwdata[`INT_BITS-1:0])
                                         | events;
               end
               `INT_MASK_IDX: begin
                  state_nxt.int_mask = pwdata[`INT_BITS-1:0];
               end
               `ZV_HIGH_IDX, `ZV_LOW_IDX, `FCS2_IDX, `FCS3_IDX: begin
                  state_nxt.slverr = 1'b0;
               end
               default: begin
                  state_nxt.slverr = 1'b1;
               end
            endcase
         end else begin
            case (idx)
               `ZV_HIGH_IDX: begin
                  // Low byte frozen so the pair is coherent
                  state_nxt.rdata[7:0] = zv_count[15:8];
                  state_nxt.low_latch  = zv_count[7:0];
                  state_nxt.pair       = rd_high_seen;
               end
               `ZV_LOW_IDX: begin
                  if (state_r.pair == rd_high_seen) begin
                     state_nxt.rdata[7:0] = state_r.low_latch;
                  end else begin
                     state_nxt.rdata[7:0] = `BYTE_RESET;
                  end
                  state_nxt.pair      = rd_idle;
                  state_nxt.low_latch = `BYTE_RESET;
               end
               `FCS2_IDX: begin
                  state_nxt.rdata[7:0] = fcs2_count;
               end
               `FCS3_IDX: begin
                  state_nxt.rdata[7:0] = fcs3_count;
               end
               `INT_STATUS_IDX: begin
                  state_nxt.rdata[`INT_BITS-1:0] = state_r.int_status;
               end
               `INT_MASK_IDX: begin
                  state_nxt.rdata[`INT_BITS-1:0] = state_r.int_mask;
               end
               default: begin
                  state_nxt.slverr = 1'b1;
               end
            endcase
         end
      end
      state_nxt.irq = |(state_nxt.int_status & state_nxt.int_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r.pair       <= rd_idle;
         state_r.low_latch  <= `BYTE_RESET;
         state_r.int_status <= '0;
         state_r.int_mask   <= '0;
         state_r.rdata      <= `WORD_ZERO;
         state_r.ready      <= 1'b0;
         state_r.slverr     <= 1'b0;
         state_r.irq        <= 1'b0;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   assign prdata  = state_r.rdata;
   assign pready  = state_r.ready;
   assign pslverr = state_r.slverr;
   assign irq     = state_r.irq;
endmodule // performance_monitor_error_counters
`default_nettype wire

// ---- verif/err_counter_checker.sv ----
/* Port assertions for the error counter bank.
   Bound to performance_monitor_error_counters from the test top; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module err_counter_checker (
   // Bus and control
   input wire logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr,
   input wire logic [15:0] paddr,
   input wire logic [31:0] prdata,
   // Events
   input wire logic        zero_violation_event, ctrl2_fcs_error_event, ctrl3_fcs_error_event
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd(a, q);
      psel && !penable && !pwrite && clk_en && paddr == a && !q;
   endsequence
   property p_clr(a, e);
      s_rd(a, e) ##1 !e ##1 s_rd(a, 1'b0) |=> prdata[7:0] == 8'h00;
   endproperty
   chk_ready_setup: assert property (psel && !penable && clk_en |=> pready)
      else $error("no answer after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("answer too long");
   chk_err_unmapped: assert property (s_rd(16'h2448, 1'b0) |=> pready && pslverr)
      else $error("unmapped not refused");
   chk_high_mapped: assert property (s_rd(16'h2440, 1'b0) |=> !pslverr)
      else $error("high byte refused");
   chk_high_clear: assert property (p_clr(16'h2440, zero_violation_event))
      else $error("high byte not cleared");
   chk_fcs2_clear: assert property (p_clr(16'h2470, ctrl2_fcs_error_event))
      else $error("fcs2 not cleared");
   chk_fcs3_clear: assert property (p_clr(16'h24b0, ctrl3_fcs_error_event))
      else $error("fcs3 not cleared");
   chk_byte_wide: assert property (pready && !pwrite && !pslverr |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
endmodule // err_counter_checker
`default_nettype wire

// ---- verif/performance_monitor_error_counters_test.sv ----
/* Self-checking test of the error counter bank.
   Drives APB and event pulses on pclk; clk_en held high. */
`timescale 1ns/1ps
`default_nettype none
module performance_monitor_error_counters_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [2:0]  evs;
   int          bad_count, checked;
   performance_monitor_error_counters u_dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .zero_violation_event(evs[0]),
      .ctrl2_fcs_error_event(evs[1]), .ctrl3_fcs_error_event(evs[2]), .irq);
   task automatic chk(string s, logic [7:0] e, logic [7:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(logic w, logic [15:0] a, logic [7:0] d);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
   endtask
   task automatic idle;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   task automatic rd(logic [15:0] a, logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk("prdata", e, rdat[7:0]);
      chk("pslverr", 8'h00, {7'h0, err});
   endtask
   task automatic ev(int i, int n);
      evs[i] <= 1'b1;
      repeat (n) @(posedge pclk);
      evs[i] <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic t_err;
      apb(1'b0, 16'h2448, 8'h00);
      chk("unmapped", 8'h01, {7'h0, err});
      apb(1'b0, 16'h2441, 8'h00);
      chk("misaligned", 8'h01, {7'h0, err});
      apb(1'b1, 16'h2470, 8'h5a);
      rd(16'h2470, 8'h00);
      idle;
      $display("error test done");
   endtask
   task automatic t_zv;
      ev(0, 300);
      rd(16'h2440, 8'h01);
      rd(16'h2444, 8'h2c);
      rd(16'h2440, 8'h00);
      rd(16'h2440, 8'h00);
      rd(16'h2444, 8'h00);
      idle;
      ev(0, 3);
      rd(16'h2440, 8'h00);
      rd(16'h2444, 8'h03);
      idle;
      $display("zero violation test done");
   endtask
   task automatic t_fcs;
      ev(1, 5);
      ev(2, 7);
      rd(16'h2470, 8'h05);
      rd(16'h2470, 8'h00);
      rd(16'h24b0, 8'h07);
      rd(16'h24b0, 8'h00);
      idle;
      ev(1, 260);
      rd(16'h2470, 8'hff);
      idle;
      $display("fcs test done");
   endtask
   task automatic t_irq;
      apb(1'b1, 16'h2500, 8'h07);
      apb(1'b1, 16'h2504, 8'h01);
      idle;
      ev(1, 1);
      @(posedge pclk);
      chk("irq masked", 8'h00, {7'h0, irq});
      ev(0, 1);
      @(posedge pclk);
      chk("irq", 8'h01, {7'h0, irq});
      rd(16'h2500, 8'h03);
      apb(1'b1, 16'h2500, 8'h01);
      idle;
      @(posedge pclk);
      chk("irq cleared", 8'h00, {7'h0, irq});
      $display("irq test done");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      #200000;
      bad_count++;
      complete_run;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, evs} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_err;
      t_zv;
      t_fcs;
      t_irq;
      complete_run;
   end
endmodule // performance_monitor_error_counters_test
bind performance_monitor_error_counters err_counter_checker u_chk (.pclk, .presetn, .clk_en, .psel, .penable,
   .pwrite, .pready, .pslverr, .paddr, .prdata, .zero_violation_event, .ctrl2_fcs_error_event,
   .ctrl3_fcs_error_event);
`default_nettype wire
